// ==== design/acrs_top.v ====
// Purpose: second control register, sampling control and result store of a 12-bit converter
// Assumes: core returns a result with a one-cycle valid strobe; pins are asynchronous
// Notes: in pulse mode sampling length counts divided conversion clock ticks, else it follows the trigger; conversion ends on the core valid strobe
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "acrs_regs.vh"
module acrs_top (
	// clock and reset
	input  wire                    mclk,
	input  wire                    reset_n,
	// register port
	input  wire [`ACRS_ADDR_W-1:0] reg_addr,
	input  wire [15:0]             reg_wdata,
	input  wire                    reg_wr,
	input  wire                    reg_rd,
	output reg  [15:0]             reg_rdata_r,
	// timer outputs and clock sources, asynchronous
	input  wire                    first_timer_output_one,
	input  wire                    second_timer_output_zero,
	input  wire                    second_timer_output_one,
	input  wire                    internal_conv_oscillator,
	input  wire                    aux_clock,
	input  wire                    main_clock,
	input  wire                    sub_main_clock,
	// converter core
	input  wire                    core_result_valid,
	input  wire [11:0]             core_result,
	output reg                     sampling_signal_r,
	output reg                     core_convert_r,
	output reg  [3:0]              core_slot_r,
	output reg                     conversion_active_r
);
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_SAMP = 2'h2;
	localparam ST_CONV = 2'h3;

	// control state
	reg         conversion_enable_r;
	reg         software_start_r;
	reg  [15:0] ctl1_r;
	reg  [15:0] ready_r;
	reg  [11:0] mem_r [0:15];
	reg  [1:0]  state_r;
	reg  [7:0]  tcnt_r;
	reg  [3:0]  slot_r;
	reg         trig_prev_r;
	reg  [6:0]  sync1_r;
	reg  [6:0]  sync2_r;

	wire [3:0]  start_slot_index      = ctl1_r[15:12];
	wire [1:0]  sample_trigger_source = ctl1_r[11:10];
	wire        pulse_sampling_select = ctl1_r[9];
	wire        trigger_invert        = ctl1_r[8];
	wire [2:0]  conv_clock_divider    = ctl1_r[7:5];
	wire [1:0]  conv_clock_source     = ctl1_r[4:3];
	wire [1:0]  sequence_mode_select  = ctl1_r[2:1];

	wire        conv_tick;
	wire        is_mem  = (reg_addr & `ACRS_OFF_MEM_MASK) == `ACRS_OFF_MEM0;
	wire [3:0]  mem_idx = reg_addr[3:0];
	wire        wr_ctl0 = reg_wr && reg_addr == `ACRS_OFF_CTL0;
	wire        wr_ctl1 = reg_wr && reg_addr == `ACRS_OFF_CTL1;
	wire        wr_flag = reg_wr && reg_addr == `ACRS_OFF_FLAGS;

	// two flops on every pin before use
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_r <= 7'h00;
			sync2_r <= 7'h00;
		end else begin
			sync1_r <= {sub_main_clock, main_clock, aux_clock, internal_conv_oscillator,
				second_timer_output_one, second_timer_output_zero, first_timer_output_one};
			sync2_r <= sync1_r;
		end
	end

	acrs_clkdiv u_div (
		.mclk    (mclk),
		.reset_n (reset_n),
		.src_sel (conv_clock_source),
		.div_sel (conv_clock_divider),
		.src_lvl (sync2_r[6:3]),
		.tick_r  (conv_tick)
	);

	// trigger selection and polarity
	reg trig_sel;
	always @* begin
		case (sample_trigger_source)  // [RQ3]
		`ACRS_SHS_SOFT:   trig_sel = software_start_r;
		`ACRS_SHS_T1OUT1: trig_sel = sync2_r[0];
		`ACRS_SHS_T2OUT0: trig_sel = sync2_r[1];
		`ACRS_SHS_T2OUT1: trig_sel = sync2_r[2];
		default:          trig_sel = 1'b0;
		endcase
	end
	wire trig     = trig_sel ^ trigger_invert;  // [RQ5]
	wire trig_up  = trig & ~trig_prev_r;
	wire is_seq   = sequence_mode_select[0];
	wire is_rpt   = sequence_mode_select[1];  // [RQ8]
	// sequences end after the last slot; no end-of-sequence marks here
	wire last     = !is_seq || slot_r == 4'hf;
	wire samp_end = pulse_sampling_select ? (conv_tick && tcnt_r == 8'h00)
		: !trig;  // [RQ4]

	// sequencer
	reg [1:0] state_nxt;
	always @* begin
		state_nxt = state_r;
		case (state_r)
		ST_IDLE: if (conversion_enable_r && trig_up) state_nxt = ST_SAMP;
		ST_WAIT: if (!conversion_enable_r) state_nxt = ST_IDLE;
			else if (is_seq && !pulse_sampling_select ? trig_up : trig_up || pulse_sampling_select)
				state_nxt = ST_SAMP;
		ST_SAMP: if (samp_end) state_nxt = ST_CONV;
		ST_CONV: if (core_result_valid)
				state_nxt = (last && !is_rpt) ? ST_IDLE : ST_WAIT;  // [RQ8]
		default: state_nxt = ST_IDLE;
		endcase
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_r             <= ST_IDLE;
			tcnt_r              <= 8'h00;
			slot_r              <= 4'h0;
			trig_prev_r         <= 1'b0;
			sampling_signal_r   <= 1'b0;
			core_convert_r      <= 1'b0;
			core_slot_r         <= 4'h0;
			conversion_active_r <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			trig_prev_r <= trig;
			core_convert_r <= 1'b0;
			if (state_r == ST_IDLE)
				slot_r <= start_slot_index;  // [RQ2]
			if (state_nxt == ST_SAMP && state_r != ST_SAMP)
				tcnt_r <= `ACRS_SAMPLE_CYCLES;
			else if (state_r == ST_SAMP && conv_tick && tcnt_r != 8'h00)
				tcnt_r <= tcnt_r - 8'h01;
			if (state_nxt == ST_CONV && state_r == ST_SAMP)
				core_convert_r <= 1'b1;
			if (state_r == ST_CONV && core_result_valid)
				slot_r <= (last ? start_slot_index : slot_r + 4'h1);
			sampling_signal_r   <= state_nxt == ST_SAMP;  // [RQ4]
			// slot must already stand beside the convert pulse
			core_slot_r         <= state_nxt == ST_CONV ? slot_r : core_slot_r;  // [RQ2]
			conversion_active_r <= state_nxt != ST_IDLE;  // [RQ9]
		end
	end

	// registers
	integer i;
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			conversion_enable_r <= 1'b0;
			software_start_r    <= 1'b0;
			ctl1_r              <= `ACRS_CTL1_RESET;
			ready_r             <= 16'h0000;
			for (i = 0; i < 16; i = i + 1)
				mem_r[i] <= 12'h000;
		end else begin
			if (wr_ctl0) begin
				conversion_enable_r <= reg_wdata[`ACRS_CTL0_ENC];
				software_start_r    <= reg_wdata[`ACRS_CTL0_SC];  // [RQ12]
			end else if (software_start_r && trig_up) begin
				software_start_r <= 1'b0;  // [RQ12]
			end
			if (wr_ctl1 && !conversion_enable_r)  // [RQ1]
				ctl1_r <= reg_wdata & `ACRS_CTL1_CFG_MASK;
			if (reg_wr && is_mem)
				mem_r[mem_idx] <= reg_wdata[11:0];  // [RQ10]
			if (wr_flag)
				ready_r <= reg_wdata;
			// access clears, a load in the same cycle wins
			if ((reg_rd || reg_wr) && is_mem)
				ready_r[mem_idx] <= 1'b0;  // [RQ13]
			if (state_r == ST_CONV && core_result_valid) begin
				mem_r[slot_r]   <= core_result;  // [RQ10]
				ready_r[slot_r] <= 1'b1;  // [RQ13]
			end
		end
	end

	// read data, one cycle after strobe
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata_r <= 16'h0000;
		end else if (reg_rd) begin
			if (is_mem)
				reg_rdata_r <= {4'h0, mem_r[mem_idx]};  // [RQ11]
			else if (reg_addr == `ACRS_OFF_CTL0)
				reg_rdata_r <= {14'h0000, conversion_enable_r, software_start_r};
			else if (reg_addr == `ACRS_OFF_CTL1)
				reg_rdata_r <= {ctl1_r[15:1], conversion_active_r};  // [RQ9]
			else if (reg_addr == `ACRS_OFF_FLAGS)
				reg_rdata_r <= ready_r;
			else
				reg_rdata_r <= 16'h0000;
		end else begin
			reg_rdata_r <= 16'h0000;
		end
	end
endmodule
`default_nettype wire

// ==== design/acrs_regs.vh ====
// Purpose: register map, field layout and timing constants of the converter control block
// Assumes: 16-bit registers on a plain strobe port, word index addressing
// Notes: offsets are local indices, not bus byte addresses
//
// Summary of operation
// RQ1 - config fields writable only while enable clear
// RQ2 - start index bits 15-12 pick first slot
// RQ3 - trigger source: soft, t1out1, t2out0, t2out1
// RQ4 - pulse mode uses sampling timer, else trigger
// RQ5 - invert bit inverts selected trigger input
// RQ6 - clock divider divides by field plus one
// RQ7 - clock source: osc, aux, main, sub-main
// RQ8 - sequence modes: single, sequence, repeat variants
// RQ9 - busy bit reads one while active
// RQ10 - result twelve bits right-justified
// RQ11 - result upper four bits read zero
// RQ12 - software start self-clears, settable with enable
// RQ13 - ready flag set on load, cleared on access
`ifndef ACRS_REGS_VH
`define ACRS_REGS_VH

`define ACRS_ADDR_W        6
`define ACRS_OFF_CTL0      6'h00
`define ACRS_OFF_CTL1      6'h01
`define ACRS_OFF_FLAGS     6'h02
`define ACRS_OFF_MEM0      6'h10
`define ACRS_OFF_MEM_MASK  6'h30

`define ACRS_CTL0_SC       0
`define ACRS_CTL0_ENC      1
`define ACRS_CTL0_RESET    2'h0

`define ACRS_CTL1_BUSY     0
`define ACRS_CTL1_RESET    16'h0000
`define ACRS_CTL1_CFG_MASK 16'hfffe

`define ACRS_SHS_SOFT      2'h0
`define ACRS_SHS_T1OUT1    2'h1
`define ACRS_SHS_T2OUT0    2'h2
`define ACRS_SHS_T2OUT1    2'h3

`define ACRS_SEQ_SINGLE    2'h0
`define ACRS_SEQ_SEQ       2'h1
`define ACRS_SEQ_RPT_ONE   2'h2
`define ACRS_SEQ_RPT_SEQ   2'h3

`define ACRS_SAMPLE_CYCLES 8'h04
`define ACRS_CONV_CYCLES   8'h0d

`endif

// ==== design/acrs_clkdiv.v ====
// Purpose: conversion clock source selection and integer divider
// Assumes: source clocks are already sampled into the mclk domain
// Notes: output is a one-cycle tick per divided period, not a clock
`timescale 1ns/1ps
`default_nettype none
`include "acrs_regs.vh"
module acrs_clkdiv (
	// clock and reset
	input  wire       mclk,
	input  wire       reset_n,
	// configuration
	input  wire [1:0] src_sel,
	input  wire [2:0] div_sel,
	// synchronised source levels
	input  wire [3:0] src_lvl,
	// divided tick
	output reg        tick_r
);
	reg        prev_r;
	reg  [2:0] cnt_r;
	wire       lvl  = src_lvl[src_sel];  // [RQ7]
	wire       rise = lvl & ~prev_r;

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			prev_r <= 1'b0;
			cnt_r  <= 3'h0;
			tick_r <= 1'b0;
		end else begin
			prev_r <= lvl;
			tick_r <= 1'b0;
			if (rise) begin
				if (cnt_r >= div_sel) begin  // [RQ6]
					cnt_r  <= 3'h0;
					tick_r <= 1'b1;
				end else begin
					cnt_r <= cnt_r + 3'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== testbench/acrs_top_assertions.sv ====
// Purpose: port checks for acrs_top
// Assumes: enable changes only by software writes
// Notes: config mirror is rebuilt from bus writes, not read from the design
`timescale 1ns/1ps
`default_nettype none
`include "acrs_regs.vh"
module acrs_top_assertions (
	// clock and reset
	input wire logic                    mclk,
	input wire logic                    reset_n,
	// register port
	input wire logic [`ACRS_ADDR_W-1:0] reg_addr,
	input wire logic [15:0]             reg_wdata,
	input wire logic                    reg_wr,
	input wire logic                    reg_rd,
	input wire logic [15:0]             reg_rdata_r,
	// converter core
	input wire logic                    core_result_valid,
	input wire logic                    sampling_signal_r,
	input wire logic                    core_convert_r,
	input wire logic [3:0]              core_slot_r,
	input wire logic                    conversion_active_r
);
	logic        en_r;
	logic [15:0] cfg_r;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// mirror of enable and locked config
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			en_r <= 1'b0;
			cfg_r <= 16'h0000;
		end else if (reg_wr) begin
			if (reg_addr == `ACRS_OFF_CTL0)
				en_r <= reg_wdata[1];
			if (reg_addr == `ACRS_OFF_CTL1 && !en_r)
				cfg_r <= reg_wdata & `ACRS_CTL1_CFG_MASK;
		end
	end
	cfg_lock_a: assert property ($past(reg_rd) && $past(reg_addr) == `ACRS_OFF_CTL1
		|-> reg_rdata_r[15:1] == $past(cfg_r[15:1])) else $error("config readback wrong");
	busy_rd_a: assert property ($past(reg_rd) && $past(reg_addr) == `ACRS_OFF_CTL1
		|-> reg_rdata_r[0] == $past(conversion_active_r)) else $error("busy bit wrong");
	slot_hi_a: assert property ($past(reg_rd) && $past(reg_addr[5:4]) == 2'h1
		|-> reg_rdata_r[15:12] == 4'h0) else $error("slot upper bits set");
	samp_busy_a: assert property (sampling_signal_r |-> conversion_active_r)
		else $error("sampling without busy");
	conv_busy_a: assert property (core_convert_r |-> conversion_active_r)
		else $error("convert without busy");
	start_slot_a: assert property (core_convert_r && cfg_r[2:1] == `ACRS_SEQ_SINGLE
		|-> core_slot_r == cfg_r[15:12]) else $error("wrong start slot");
	soft_go_a: assert property (reg_wr && reg_addr == `ACRS_OFF_CTL0 && reg_wdata[1:0] == 2'h3
		&& !en_r && !conversion_active_r && cfg_r[11:10] == `ACRS_SHS_SOFT
		|-> ##[1:4] conversion_active_r) else $error("soft start ignored");
	idle_rst_a: assert property ($rose(reset_n) |-> !conversion_active_r && !sampling_signal_r)
		else $error("busy after reset");
	cover property ($rose(conversion_active_r));
	cover property ($fell(sampling_signal_r));
	cover property (core_result_valid);
endmodule
bind acrs_top acrs_top_assertions acrs_top_assertions_inst (.mclk(mclk), .reset_n(reset_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata_r(reg_rdata_r), .core_result_valid(core_result_valid),
	.sampling_signal_r(sampling_signal_r), .core_convert_r(core_convert_r),
	.core_slot_r(core_slot_r), .conversion_active_r(conversion_active_r));
`default_nettype wire

// ==== testbench/acrs_core_model.sv ====
// Purpose: behavioural conversion core
// Assumes: result due a fixed delay after the convert pulse
// Notes: result lines toggle outside the valid cycle so stale data never matches
`timescale 1ns/1ps
`default_nettype none
module acrs_core_model #(
	parameter int DLY = 3
) (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        start,
	input  wire logic [11:0] val,
	output var  logic        valid,
	output var  logic [11:0] res
);
	int cnt;
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			valid <= 1'b0;
			res <= 12'h000;
			cnt <= 0;
		end else begin
			valid <= cnt == 1;
			res <= (cnt == 1) ? val : ~res;
			cnt <= start ? DLY : (cnt > 0 ? cnt - 1 : 0);
		end
	end
endmodule
`default_nettype wire

// ==== testbench/test_adc_control_and_result_store.sv ====
// Purpose: directed bench for acrs_top
// Assumes: main clock source at 32 ns, other sources held low
// Notes: divider checked by sampling width bounds, since the first tick phase is free
`timescale 1ns/1ps
`default_nettype none
`include "acrs_regs.vh"
module test_adc_control_and_result_store;
	logic        mclk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic        trg = 1'b1, mck = 1'b0, cv, cvalid, samp, busy;
	logic [5:0]  reg_addr = 6'h00;
	logic [15:0] reg_wdata = 16'h0000, rdata, q;
	logic [11:0] cres, cval = 12'habc;
	logic [3:0]  slot;
	int          err_total = 0, compares = 0, n1, n8;
	always #4 mclk = ~mclk;
	always #16 mck = ~mck;
	acrs_top acrs_top_inst (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(rdata),
		.first_timer_output_one(trg), .second_timer_output_zero(1'b0),
		.second_timer_output_one(1'b0), .internal_conv_oscillator(1'b0),
		.aux_clock(1'b0), .main_clock(mck), .sub_main_clock(1'b0),
		.core_result_valid(cvalid), .core_result(cres), .sampling_signal_r(samp),
		.core_convert_r(cv), .core_slot_r(slot), .conversion_active_r(busy));
	acrs_core_model acrs_core_model_inst (.mclk(mclk), .reset_n(reset_n), .start(cv),
		.val(cval), .valid(cvalid), .res(cres));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [15:0] e);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	// bounded wait; a hang ends the run
	task automatic wt(ref logic s, input logic v, output int n);
		n = 0;
		while (s !== v && n < 900) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 900) begin
			err_total++;
			finish_test;
		end
	endtask
	task finish_test;
		$display("counts: %0d compares, %0d mismatches", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		rd(`ACRS_OFF_CTL1, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			q = {i[3:0], i[1:0], i[0], i[1], i[2:0], i[1:0], i[1:0], 1'b0};
			wr(`ACRS_OFF_CTL1, q | 16'h0001);
			rd(`ACRS_OFF_CTL1, q);
		end
		$display("test fields done");
		wr(`ACRS_OFF_CTL1, 16'h5210);
		wr(`ACRS_OFF_CTL0, 16'h0003);
		wt(samp, 1'b1, n1);
		wt(samp, 1'b0, n1);
		chk({15'h0000, n1 > `ACRS_SAMPLE_CYCLES * 4 &&
			n1 <= (`ACRS_SAMPLE_CYCLES + 1) * 4}, 16'h0001);
		wt(busy, 1'b0, n1);
		rd(`ACRS_OFF_FLAGS, 16'h0020);
		rd(`ACRS_OFF_MEM0 + 6'h05, 16'h0abc);
		rd(`ACRS_OFF_FLAGS, 16'h0000);
		rd(`ACRS_OFF_CTL0, 16'h0002);
		rd(`ACRS_OFF_CTL1, 16'h5210);
		$display("test single done");
		wr(`ACRS_OFF_CTL0, 16'h0000);
		wr(`ACRS_OFF_CTL1, 16'he212);
		wr(`ACRS_OFF_CTL0, 16'h0003);
		wt(busy, 1'b1, n1);
		wt(busy, 1'b0, n1);
		rd(`ACRS_OFF_FLAGS, 16'hc000);
		$display("test sequence done");
		wr(`ACRS_OFF_CTL0, 16'h0000);
		wr(`ACRS_OFF_CTL1, 16'h52f0);
		wr(`ACRS_OFF_CTL0, 16'h0003);
		wt(samp, 1'b1, n8);
		wt(samp, 1'b0, n8);
		chk({15'h0000, n8 > `ACRS_SAMPLE_CYCLES * 32 &&
			n8 <= (`ACRS_SAMPLE_CYCLES + 1) * 32}, 16'h0001);
		wt(busy, 1'b0, n8);
		$display("test divider done");
		wr(`ACRS_OFF_CTL0, 16'h0000);
		cval <= 12'h123;
		wr(`ACRS_OFF_CTL1, 16'h5510);
		wr(`ACRS_OFF_CTL0, 16'h0002);
		repeat (10) @(posedge mclk);
		chk({15'h0000, samp}, 16'h0000);
		trg <= 1'b0;
		wt(samp, 1'b1, n1);
		wr(`ACRS_OFF_CTL1, 16'h0000);
		rd(`ACRS_OFF_CTL1, 16'h5511);
		chk({15'h0000, samp}, 16'h0001);
		@(posedge mclk);
		trg <= 1'b1;
		wt(samp, 1'b0, n1);
		wt(busy, 1'b0, n1);
		rd(`ACRS_OFF_MEM0 + 6'h05, 16'h0123);
		$display("test extended done");
		finish_test;
	end
endmodule
`default_nettype wire
